// ===== logic/bcs_pkg.sv
// shared types and constants for the branch, call and skip unit
package bcs_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_W  = 22;
  localparam int CNT_W = 3;

  // ----------------------------------------------------------------
  // status flag bit positions
  // ----------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // ----------------------------------------------------------------
  // cycle counts per instruction outcome
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CYC_BR_NT   = 3'h1;
  localparam logic [CNT_W-1:0] CYC_BR_TK   = 3'h2;
  localparam logic [CNT_W-1:0] CYC_SKIP_NO = 3'h1;
  localparam logic [CNT_W-1:0] CYC_SKIP_1W = 3'h2;
  localparam logic [CNT_W-1:0] CYC_SKIP_2W = 3'h3;
  localparam logic [CNT_W-1:0] CYC_IO_ADD  = 3'h1;
  localparam logic [CNT_W-1:0] CYC_CMP     = 3'h1;
  localparam logic [CNT_W-1:0] CYC_CALL    = 3'h3;
  localparam logic [CNT_W-1:0] CYC_RET     = 3'h5;

  // ----------------------------------------------------------------
  // register port map and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_EXT_SEG = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h1;
  localparam logic [5:0] EXT_SEG_RST = 6'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_RELATIVE_SUBROUTINE_CALL, OP_PTR_CALL, OP_EXT_CALL, OP_RET, OP_INTERRUPT_RETURN,
    OP_COMPARE_SKIP_EQUAL, OP_CP, OP_CPC, OP_CPI, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
    OP_BR_SET, OP_BR_CLR
  } bcs_op_t;

  typedef enum logic {ST_IDLE, ST_BUSY} bcs_state_t;

  typedef struct packed {
    bcs_op_t     op;
    logic [7:0]  rd_val;
    logic [7:0]  rr_val;     // second register or immediate
    logic [2:0]  bit_sel;    // register/io bit or status flag index
    logic [7:0]  io_val;
    logic [11:0] k;          // signed word offset, sign extended by decoder
    logic        next_2w;    // following instruction is two words long
  } bcs_issue_t;

  typedef struct packed {
    logic            pc_load;
    logic [PC_W-1:0] pc;
    logic            flags_we;
    logic [7:0]      flags;
  } bcs_result_t;
endpackage : bcs_pkg

// ===== logic/bcs_unit.sv
// control-flow execution unit: calls, returns, compares, skips, branches
`timescale 1ns/1ps

module bcs_unit
  import bcs_pkg::*;
(
  // clock, reset, enable
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ce,
  // instruction issue
  input  wire logic            issue_valid,
  input  wire bcs_issue_t      issue,
  input  wire logic [PC_W-1:0] pc_in,
  input  wire logic [15:0]     z_ptr,
  input  wire logic [7:0]      flags_in,
  // stack
  input  wire logic [PC_W-1:0] stack_data,
  output bcs_result_t          result,
  output logic                 stack_push,
  output logic [PC_W-1:0]      stack_push_data,
  output logic                 stack_pop,
  // status
  output logic                 busy,
  output logic                 done,
  // register port
  input  wire logic [3:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_we,
  input  wire logic            reg_re,
  output logic [7:0]           reg_rdata
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // subtract flags; keep_z chains the zero flag across a multi-byte compare
  function automatic logic [7:0] sub_flags(input logic [7:0] d, input logic [7:0] r,
                                           input logic cin, input logic keep_z,
                                           input logic [7:0] f);
    logic [7:0] res;
    logic [7:0] o;
    res = d - r - {7'h00, cin};
    o = f;
    o[FLG_H] = (~d[3] & r[3]) | (r[3] & res[3]) | (res[3] & ~d[3]);
    o[FLG_C] = (~d[7] & r[7]) | (r[7] & res[7]) | (res[7] & ~d[7]);
    o[FLG_V] = (d[7] & ~r[7] & ~res[7]) | (~d[7] & r[7] & res[7]);
    o[FLG_N] = res[7];
    o[FLG_S] = o[FLG_N] ^ o[FLG_V];
    o[FLG_Z] = (res == 8'h00) & (keep_z ? f[FLG_Z] : 1'b1);
    return o;
  endfunction : sub_flags

  // flag selected by index; S is rebuilt from N xor V for the signed branches
  function automatic logic flag_bit(input logic [7:0] f, input logic [2:0] s);
    logic v;
    v = f[s];
    if (s == 3'(FLG_S)) begin
      v = f[FLG_N] ^ f[FLG_V];
    end
    return v;
  endfunction : flag_bit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bcs_state_t       state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg;
  bcs_op_t          op_reg;
  logic [PC_W-1:0]  tgt_reg;
  logic [7:0]       flg_reg;
  logic [5:0]       ext_seg_reg;
  logic             last_skip_reg;
  logic             last_taken_reg;

  // ----------------------------------------------------------------
  // decode of the issued instruction
  // ----------------------------------------------------------------
  wire logic            accept   = issue_valid & (state_reg == ST_IDLE);
  wire logic [PC_W-1:0] pc_seq   = pc_in + 22'h000001;
  wire logic [PC_W-1:0] pc_rel   = pc_in + {{10{issue.k[11]}}, issue.k} + 22'h000001;
  wire logic [PC_W-1:0] pc_skip  = pc_in + (issue.next_2w ? 22'h000003 : 22'h000002);
  wire logic            sel_flag = flag_bit(flags_in, issue.bit_sel);
  wire logic            rbit     = issue.rr_val[issue.bit_sel];
  wire logic            iobit    = issue.io_val[issue.bit_sel];
  wire logic [CNT_W-1:0] skip_cyc = issue.next_2w ? CYC_SKIP_2W : CYC_SKIP_1W;
  wire logic            is_call  = (issue.op == OP_RELATIVE_SUBROUTINE_CALL) | (issue.op == OP_PTR_CALL)
                                 | (issue.op == OP_EXT_CALL);
  wire logic            is_ret   = (issue.op == OP_RET) | (issue.op == OP_INTERRUPT_RETURN);

  // skip or branch decision; a skip is a taken jump over the next word(s)
  logic             jump;
  logic [PC_W-1:0]  tgt;
  logic [CNT_W-1:0] cyc;
  logic [7:0]       flg;
  logic             flg_we;
  always_comb begin
    jump   = 1'b0;
    tgt    = pc_seq;
    cyc    = CYC_BR_NT;
    flg    = flags_in;
    flg_we = 1'b0;
    case (issue.op)
      OP_RELATIVE_SUBROUTINE_CALL: begin
        tgt = pc_rel;
        cyc = CYC_CALL;
      end
      OP_PTR_CALL: begin
        tgt = {6'h00, z_ptr};
        cyc = CYC_CALL;
      end
      OP_EXT_CALL: begin
        tgt = {ext_seg_reg, z_ptr};
        cyc = CYC_CALL;
      end
      OP_RET, OP_INTERRUPT_RETURN: begin
        cyc = CYC_RET;
        if (issue.op == OP_INTERRUPT_RETURN) begin
          flg[FLG_I] = 1'b1;
          flg_we     = 1'b1;
        end
      end
      OP_COMPARE_SKIP_EQUAL: begin
        jump = (issue.rd_val == issue.rr_val);
      end
      OP_CP, OP_CPI: begin
        flg    = sub_flags(issue.rd_val, issue.rr_val, 1'b0, 1'b0, flags_in);
        flg_we = 1'b1;
        cyc    = CYC_CMP;
      end
      OP_CPC: begin
        flg    = sub_flags(issue.rd_val, issue.rr_val, flags_in[FLG_C], 1'b1, flags_in);
        flg_we = 1'b1;
        cyc    = CYC_CMP;
      end
      OP_SKIP_REG_BIT_CLEAR: jump = ~rbit;
      OP_SKIP_REG_BIT_SET: jump = rbit;
      OP_SKIP_IO_BIT_CLEAR: jump = ~iobit;
      OP_SKIP_IO_BIT_SET: jump = iobit;
      // H, T, V, I, C are plain flag selects
      OP_BR_SET: jump = sel_flag;
      OP_BR_CLR: jump = ~sel_flag;
      default: begin
        jump = 1'b0;
      end
    endcase
    // skips cost one more per skipped word on a taken skip, io skips one more throughout
    if ((issue.op >= OP_COMPARE_SKIP_EQUAL) && (issue.op != OP_CP) && (issue.op != OP_CPC)
        && (issue.op != OP_CPI) && (issue.op < OP_BR_SET)) begin
      cyc = jump ? skip_cyc : CYC_SKIP_NO;
      tgt = jump ? pc_skip : pc_seq;
      if ((issue.op == OP_SKIP_IO_BIT_CLEAR) || (issue.op == OP_SKIP_IO_BIT_SET)) begin
        cyc = cyc + CYC_IO_ADD;
      end
    end
    if ((issue.op == OP_BR_SET) || (issue.op == OP_BR_CLR)) begin
      cyc = jump ? CYC_BR_TK : CYC_BR_NT;
      tgt = jump ? pc_rel : pc_seq;
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  wire logic last = (state_reg == ST_BUSY) & (cnt_reg == 3'h1);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (accept) state_next = ST_BUSY;
      ST_BUSY: if (last) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // instruction context latched at issue
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 3'h0;
      op_reg    <= OP_NONE;
      tgt_reg   <= 22'h000000;
      flg_reg   <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      if (accept) begin
        cnt_reg <= cyc;
        op_reg  <= issue.op;
        tgt_reg <= tgt;
        flg_reg <= flg;
      end else if (state_reg == ST_BUSY) begin
        cnt_reg <= cnt_reg - 3'h1;
      end
    end
  end

  // result and stack strobes, all registered; return pc taken at the last edge
  always_ff @(posedge clk) begin
    if (rst) begin
      result          <= '0;
      stack_push      <= 1'b0;
      stack_push_data <= 22'h000000;
      stack_pop       <= 1'b0;
      done            <= 1'b0;
      busy            <= 1'b0;
    end else if (ce) begin
      stack_push <= accept & is_call;
      stack_pop  <= accept & is_ret;
      if (accept) begin
        stack_push_data <= pc_seq;
      end
      done           <= last;
      busy           <= (state_next == ST_BUSY);
      result.pc_load <= last;
      result.flags_we <= last & ((op_reg == OP_CP) | (op_reg == OP_CPC)
                                 | (op_reg == OP_CPI) | (op_reg == OP_INTERRUPT_RETURN));
      if (last) begin
        result.pc    <= ((op_reg == OP_RET) || (op_reg == OP_INTERRUPT_RETURN)) ? stack_data : tgt_reg;
        result.flags <= flg_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // segment register steers the extended pointer call target
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_seg_reg    <= EXT_SEG_RST;
      last_skip_reg  <= 1'b0;
      last_taken_reg <= 1'b0;
      reg_rdata      <= 8'h00;
    end else if (ce) begin
      if (reg_we && (reg_addr == REG_EXT_SEG)) begin
        ext_seg_reg <= reg_wdata[5:0];
      end
      if (accept) begin
        last_taken_reg <= jump | is_call | is_ret;
        last_skip_reg  <= jump & (issue.op >= OP_COMPARE_SKIP_EQUAL) & (issue.op < OP_BR_SET);
      end
      if (reg_re) begin
        case (reg_addr)
          REG_EXT_SEG: reg_rdata <= {2'h0, ext_seg_reg};
          REG_STATUS:  reg_rdata <= {5'h00, last_skip_reg, last_taken_reg, busy};
          default:     reg_rdata <= 8'h00;  // unmapped reads zero
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence issued(bcs_op_t o);
    ce && issue_valid && (state_reg == ST_IDLE) && (issue.op == o);
  endsequence
  sequence ends_in(int n);
    (!done)[*1] ##0 1'b1;
  endsequence

  // issue edge, then one ce edge per cycle; done is seen on the edge after the last
  ptr_call_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_PTR_CALL) ##1 ce[*3] |=> (done && result.pc[21:16] == 6'h00
      && result.pc[15:0] == $past(z_ptr, 4)))
    else $error("pointer call target wrong");
  ext_call_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_EXT_CALL) ##1 ce[*3] |=> (done && result.pc == {$past(ext_seg_reg, 4), $past(z_ptr, 4)}))
    else $error("extended call target wrong");
  compare_skip_equal_skip_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_COMPARE_SKIP_EQUAL) ##0 (issue.rd_val == issue.rr_val) && !issue.next_2w ##1 ce[*2]
      |-> ##1 (done && !result.flags_we && result.pc == $past(pc_in, 3) + 22'h000002))
    else $error("compare skip failed");
  rbit_clr_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_SKIP_REG_BIT_CLEAR) ##0 !issue.rr_val[issue.bit_sel] && issue.next_2w ##1 ce[*3]
      |-> ##1 (done && result.pc == $past(pc_in, 4) + 22'h000003))
    else $error("register bit clear skip failed");
  rbit_set_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_SKIP_REG_BIT_SET) ##0 !issue.rr_val[issue.bit_sel] ##1 ce
      |=> (done && result.pc == $past(pc_in, 2) + 22'h000001 && !result.flags_we))
    else $error("register bit set must not skip");
  io_clr_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_SKIP_IO_BIT_CLEAR) ##0 !issue.io_val[issue.bit_sel] && !issue.next_2w ##1 ce[*3] |-> ##1 done)
    else $error("io clear skip timing wrong");
  io_set_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_SKIP_IO_BIT_SET) ##0 !issue.io_val[issue.bit_sel] ##1 ce[*2] |-> !done ##1 done)
    else $error("io set no-skip timing wrong");
  br_set_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_BR_SET) ##0 (issue.bit_sel == 3'(FLG_Z)) && flags_in[FLG_Z] ##1 ce[*2]
      |-> !done ##1 (done && result.pc == $past(pc_rel, 3)))
    else $error("branch on set flag wrong");
  br_clr_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_BR_CLR) ##0 flags_in[issue.bit_sel] && (issue.bit_sel != 3'(FLG_S)) ##1 ce
      |=> (done && result.pc == $past(pc_in, 2) + 22'h000001))
    else $error("branch on clear flag taken wrongly");
  signed_ge_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_BR_CLR) ##0 (issue.bit_sel == 3'(FLG_S)) && (flags_in[FLG_N] == flags_in[FLG_V])
      |-> jump)
    else $error("signed ge not taken");
  cmp_flags_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_CP) ##0 (issue.rd_val == issue.rr_val) ##1 ce
      |=> (done && result.flags_we && result.flags[FLG_Z] && !result.flags[FLG_C]))
    else $error("compare flags wrong");
  // pop pulse follows the issue edge; done follows the fifth ce edge after it
  interrupt_return_a: assert property (@(posedge clk) disable iff (rst)
    issued(OP_INTERRUPT_RETURN) ##1 ce[*5] |-> $past(stack_pop, 4) ##1 (done && result.flags[FLG_I] && result.flags_we))
    else $error("interrupt return wrong");
endmodule : bcs_unit

// ===== sim/bcs_unit_test.sv
// self-checking bench for the branch, call and skip unit
`timescale 1ns/1ps

module bcs_unit_test import bcs_pkg::*;;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic            clk;
  logic            rst;
  logic            ce;
  logic            issue_valid;
  bcs_issue_t      issue;
  logic [PC_W-1:0] pc_in;
  logic [15:0]     z_ptr;
  logic [7:0]      flags_in;
  logic [PC_W-1:0] stack_data;
  bcs_result_t     result;
  logic            stack_push;
  logic [PC_W-1:0] stack_push_data;
  logic            stack_pop;
  logic            busy;
  logic            done;
  logic [3:0]      reg_addr;
  logic [7:0]      reg_wdata;
  logic            reg_we;
  logic            reg_re;
  logic [7:0]      reg_rdata;
  int              err_total;
  int              check_count;
  int              push_cnt;
  int              pop_cnt;
  int              n;

  localparam logic [PC_W-1:0] pc_base = 22'h000100;
  localparam logic [PC_W-1:0] ret_adr = 22'h13579b;

  typedef struct {
    bcs_op_t         op;
    logic [7:0]      rd;
    logic [7:0]      rr;
    logic [2:0]      bs;
    logic [7:0]      io;
    logic [11:0]     k;
    logic            n2w;
    logic [7:0]      fin;
    logic [PC_W-1:0] epc;
    int              cyc;
    logic            fwe;
    logic [7:0]      efl;
  } bcs_row_t;
  bcs_row_t rows[$];

  bcs_unit dut (
    .clk(clk), .rst(rst), .ce(ce), .issue_valid(issue_valid), .issue(issue), .pc_in(pc_in),
    .z_ptr(z_ptr), .flags_in(flags_in), .stack_data(stack_data), .result(result),
    .stack_push(stack_push), .stack_push_data(stack_push_data), .stack_pop(stack_pop),
    .busy(busy), .done(done), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata)
  );

  // ----------------------------------------------------------------
  // clock and pulse monitors
  // ----------------------------------------------------------------
  always #4 clk = ~clk;

  // one-cycle pulses are counted on the edge that follows them
  always @(posedge clk) begin
    if (stack_push === 1'b1) push_cnt++;
    if (stack_pop === 1'b1) pop_cnt++;
  end

  // ----------------------------------------------------------------
  // compare, report and closing tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_cyc(input string nm, input int e, input int g);
    check_count++;
    if (g != e) begin
      err_total++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cyc

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // register port and issue tasks
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    chk("reg_rdata", 32'(e), 32'(reg_rdata));
  endtask : reg_rd

  // counts clock edges until done shows, bounded at 40
  task automatic wait_done(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (done !== 1'b1 && cnt < 40);
    chk("done", 32'h1, 32'(done));
  endtask : wait_done

  task automatic iss(input bcs_op_t op);
    @(posedge clk);
    issue_valid <= 1'b1;
    issue       <= '{op, 8'h00, 8'h00, 3'h0, 8'h00, 12'h000, 1'b0};
    flags_in    <= 8'h00;
  endtask : iss

  task automatic run(input bcs_row_t r);
    logic is_call;
    logic is_ret;
    is_call = r.op inside {OP_RELATIVE_SUBROUTINE_CALL, OP_PTR_CALL, OP_EXT_CALL};
    is_ret  = r.op inside {OP_RET, OP_INTERRUPT_RETURN};
    @(posedge clk);
    issue_valid <= 1'b1;
    issue       <= '{r.op, r.rd, r.rr, r.bs, r.io, r.k, r.n2w};
    flags_in    <= r.fin;
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    push_cnt = 0;
    pop_cnt  = 0;
    wait_done(n);
    chk_cyc("cycles", r.cyc, n);
    chk("pc", 32'(r.epc), 32'(result.pc));
    chk("flags_we", 32'(r.fwe), 32'(result.flags_we));
    if (r.fwe) chk("flags", 32'(r.efl), 32'(result.flags));
    chk_cyc("pushes", int'(is_call), push_cnt);
    chk_cyc("pops", int'(is_ret), pop_cnt);
    if (is_call) chk("push_data", 32'(pc_base + 22'h1), 32'(stack_push_data));
  endtask : run

  // ----------------------------------------------------------------
  // row builders: expectations follow from the taken or skip outcome
  // ----------------------------------------------------------------
  task automatic add(input bcs_op_t op, input logic [7:0] rd, rr, input logic [2:0] bs,
                     input logic [7:0] io, input logic [11:0] k, input logic n2w, input logic [7:0] fin,
                     input logic [PC_W-1:0] epc, input int cyc, input logic fwe, input logic [7:0] efl);
    rows.push_back('{op, rd, rr, bs, io, k, n2w, fin, epc, cyc, fwe, efl});
  endtask : add

  // offset of minus sixteen words, so a taken branch lands at base - 15
  task automatic br(input bcs_op_t op, input logic [2:0] bs, input logic [7:0] fin, input logic tk);
    add(op, 8'h00, 8'h00, bs, 8'h00, 12'hff0, 1'b0, fin, tk ? pc_base - 22'hf : pc_base + 22'h1,
        tk ? 2 : 1, 1'b0, 8'h00);
  endtask : br

  // io skips cost one cycle more than register skips
  task automatic sk(input bcs_op_t op, input logic [7:0] v, input logic [2:0] bs, input logic n2w, input logic s);
    int extra;
    extra = (op == OP_SKIP_IO_BIT_CLEAR || op == OP_SKIP_IO_BIT_SET) ? 1 : 0;
    add(op, v, v, bs, v, 12'h000, n2w, 8'h5a, pc_base + (s ? 22'h2 + 22'(n2w) : 22'h1),
        (s ? 2 + int'(n2w) : 1) + extra, 1'b0, 8'h00);
  endtask : sk

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0; rst = 1'b1; ce = 1'b1; issue_valid = 1'b0; issue = '0; pc_in = pc_base;
    z_ptr = 16'hbeef; flags_in = 8'h00; stack_data = ret_adr; reg_addr = 4'h0; reg_wdata = 8'h00;
    reg_we = 1'b0; reg_re = 1'b0; err_total = 0; check_count = 0; push_cnt = 0; pop_cnt = 0;
    add(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5b, 3'h0, 8'h00, 12'h000, 1'b0, 8'h00, pc_base + 22'h1, 1, 1'b0, 8'h00);
    sk(OP_COMPARE_SKIP_EQUAL, 8'h5a, 3'h0, 1'b0, 1'b1);
    sk(OP_COMPARE_SKIP_EQUAL, 8'ha5, 3'h0, 1'b1, 1'b1);
    sk(OP_SKIP_REG_BIT_CLEAR, 8'hfb, 3'h2, 1'b1, 1'b1);
    sk(OP_SKIP_REG_BIT_CLEAR, 8'h04, 3'h2, 1'b0, 1'b0);
    sk(OP_SKIP_REG_BIT_SET, 8'h80, 3'h7, 1'b0, 1'b1);
    sk(OP_SKIP_REG_BIT_SET, 8'h7f, 3'h7, 1'b1, 1'b0);
    sk(OP_SKIP_IO_BIT_CLEAR, 8'hfe, 3'h0, 1'b0, 1'b1);
    sk(OP_SKIP_IO_BIT_CLEAR, 8'hdf, 3'h5, 1'b1, 1'b1);
    sk(OP_SKIP_IO_BIT_CLEAR, 8'h01, 3'h0, 1'b0, 1'b0);
    sk(OP_SKIP_IO_BIT_SET, 8'h40, 3'h6, 1'b1, 1'b1);
    sk(OP_SKIP_IO_BIT_SET, 8'hbf, 3'h6, 1'b0, 1'b0);
    add(OP_CP, 8'h10, 8'h20, 3'h0, 8'h00, 12'h000, 1'b0, 8'hc0, pc_base + 22'h1, 1, 1'b1, 8'hd5);
    add(OP_CP, 8'h80, 8'h01, 3'h0, 8'h00, 12'h000, 1'b0, 8'h00, pc_base + 22'h1, 1, 1'b1, 8'h38);
    add(OP_CPI, 8'h05, 8'h05, 3'h0, 8'h00, 12'h000, 1'b0, 8'h00, pc_base + 22'h1, 1, 1'b1, 8'h02);
    add(OP_CPC, 8'h05, 8'h05, 3'h0, 8'h00, 12'h000, 1'b0, 8'h01, pc_base + 22'h1, 1, 1'b1, 8'h35);
    add(OP_CPC, 8'h05, 8'h04, 3'h0, 8'h00, 12'h000, 1'b0, 8'h01, pc_base + 22'h1, 1, 1'b1, 8'h00);
    add(OP_RELATIVE_SUBROUTINE_CALL, 8'h00, 8'h00, 3'h0, 8'h00, 12'h020, 1'b0, 8'h00, pc_base + 22'h21, 3, 1'b0, 8'h00);
    add(OP_PTR_CALL, 8'h00, 8'h00, 3'h0, 8'h00, 12'h000, 1'b0, 8'h00, 22'h00beef, 3, 1'b0, 8'h00);
    add(OP_EXT_CALL, 8'h00, 8'h00, 3'h0, 8'h00, 12'h000, 1'b0, 8'h00, 22'h2abeef, 3, 1'b0, 8'h00);
    add(OP_RET, 8'h00, 8'h00, 3'h0, 8'h00, 12'h000, 1'b0, 8'h00, ret_adr, 5, 1'b0, 8'h00);
    add(OP_INTERRUPT_RETURN, 8'h00, 8'h00, 3'h0, 8'h00, 12'h000, 1'b0, 8'h00, ret_adr, 5, 1'b1, 8'h80);
    add(OP_BR_SET, 8'h00, 8'h00, 3'h2, 8'h00, 12'h7ff, 1'b0, 8'h04, pc_base + 22'h800, 2, 1'b0, 8'h00);
    br(OP_BR_SET, 3'h1, 8'h02, 1'b1);
    br(OP_BR_SET, 3'h1, 8'hfd, 1'b0);
    br(OP_BR_CLR, 3'h1, 8'h02, 1'b0);
    br(OP_BR_CLR, 3'h0, 8'hfe, 1'b1);
    br(OP_BR_CLR, 3'h0, 8'h01, 1'b0);
    br(OP_BR_CLR, 3'h4, 8'h1c, 1'b1);
    br(OP_BR_CLR, 3'h4, 8'h04, 1'b0);
    br(OP_BR_SET, 3'h4, 8'h08, 1'b1);
    br(OP_BR_SET, 3'h4, 8'h1c, 1'b0);
    br(OP_BR_SET, 3'h5, 8'h20, 1'b1);
    br(OP_BR_CLR, 3'h5, 8'h20, 1'b0);
    br(OP_BR_CLR, 3'h5, 8'hdf, 1'b1);
    br(OP_BR_SET, 3'h6, 8'h40, 1'b1);
    br(OP_BR_CLR, 3'h6, 8'hbf, 1'b1);
    br(OP_BR_SET, 3'h3, 8'hf7, 1'b0);
    br(OP_BR_SET, 3'h3, 8'h08, 1'b1);
    br(OP_BR_CLR, 3'h3, 8'h08, 1'b0);
    br(OP_BR_SET, 3'h7, 8'h80, 1'b1);
    br(OP_BR_CLR, 3'h7, 8'h80, 1'b0);
    br(OP_BR_CLR, 3'h7, 8'h7f, 1'b1);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    reg_wr(REG_EXT_SEG, 8'h2a);
    foreach (rows[i]) run(rows[i]);
    // register port: read-only status, unmapped place, six-bit segment
    reg_wr(REG_STATUS, 8'hff);
    reg_rd(REG_STATUS, 8'h02);
    reg_wr(4'h9, 8'h11);
    reg_rd(4'h9, 8'h00);
    reg_wr(REG_EXT_SEG, 8'hff);
    reg_rd(REG_EXT_SEG, 8'h3f);
    // pointer call ignores a full segment; ce low stalls the count
    iss(OP_PTR_CALL);
    @(posedge clk);
    issue_valid <= 1'b0;
    ce          <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    wait_done(n);
    chk_cyc("stalled_cycles", 3, n);
    chk("pc", 32'(22'h00beef), 32'(result.pc));
    // a second issue while busy must be ignored
    iss(OP_RET);
    @(posedge clk);
    issue <= '{OP_BR_CLR, 8'h00, 8'h00, 3'h0, 8'h00, 12'h010, 1'b0};
    repeat (2) @(posedge clk);
    issue_valid <= 1'b0;
    wait_done(n);
    chk_cyc("busy_cycles", 3, n);
    chk("pc", 32'(ret_adr), 32'(result.pc));
    // reset in mid return clears outputs and the segment
    iss(OP_RET);
    @(posedge clk);
    issue_valid <= 1'b0;
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("busy", 32'h0, 32'(busy));
    chk("pc_load", 32'h0, 32'(result.pc_load));
    reg_rd(REG_EXT_SEG, 8'h00);
    run(rows[rows.size() - 1]);
    tally_and_finish();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    err_total++;
    $display("mismatch watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule : bcs_unit_test
